// *** dram_odt_timing_control_test.sv ***
// bench joining controller and memory ends across the link interface
// assumes 100 MHz core_clk; mode inputs static within each phase
module dram_odt_timing_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	import odt_pkg::*;
	logic      core_clk = 0, rst = 1, wantTerm = 0, readBlock = 0;
	logic      writeReq = 0, writeIsBl8 = 0, holdBusy, termOn, termWrite;
	logic      dllLocked = 1, dllRelock = 0, cke = 1, prechargePd = 0;
	logic      dllOnInPd = 1;
	odt_al_t   alCode = 2'h0;
	odt_lat_t  cwl = 4'h5;
	odt_nom_t  nomCode = 3'h1, nomValue;
	odt_wr_t   wrCode = 2'h1, wrValue;
	odt_mode_e termMode;
	int        err_total = 0, n_checks = 0, dly = 0;
	logic      hist[$];
	odt_link_if link ();
	odt_ctrl_end odt_ctrl_end_i (.core_clk(core_clk), .rst(rst), .link(link),
		.wantTerm(wantTerm), .readBlock(readBlock), .writeReq(writeReq),
		.writeIsBl8(writeIsBl8), .holdBusy(holdBusy));
	odt_memory_end odt_memory_end_i (.core_clk(core_clk), .rst(rst),
		.link(link), .dllLocked(dllLocked), .dllRelock(dllRelock), .cke(cke),
		.prechargePd(prechargePd), .dllOnInPd(dllOnInPd), .alCode(alCode),
		.cwl(cwl), .nomCode(nomCode), .wrCode(wrCode), .termMode(termMode),
		.termOn(termOn), .termWrite(termWrite), .nomValue(nomValue),
		.wrValue(wrValue));
	odt_timing_checker odt_timing_checker_i (.core_clk(core_clk), .rst(rst),
		.termPin(link.termPin), .writeCmd(link.writeCmd),
		.writeBl8(link.writeBl8));
	always #5 core_clk = ~core_clk;
	task automatic check1(string nm, logic [2:0] ex, logic [2:0] sn);
		n_checks++;
		if (sn !== ex) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, ex, sn);
		end
	endtask : check1
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	// model: termOn is the pin delayed dly cycles, or held off when dly < 0
	always @(posedge core_clk) begin
		hist.push_front(link.termPin);
		if (hist.size() > 16)
			void'(hist.pop_back());
		if (dly != 0 && hist.size() > 14)
			check1("termOn", (dly < 0) ? 1'b0 : hist[dly], termOn);
	end
	// sync delay: 2 sync flops + (cwl + AL - 2) + 1 output register
	task automatic phase(odt_al_t al, logic ck, pd, don, rl, odt_nom_t nm,
		int d, odt_mode_e em);
		logic [31:0] r;
		dly = 0;
		@(posedge core_clk);
		alCode <= al;
		cke <= ck;
		prechargePd <= pd;
		dllOnInPd <= don;
		dllRelock <= rl;
		dllLocked <= !rl;
		nomCode <= nm;
		wrCode <= (nm == 3'h0) ? 2'h0 : 2'h1;
		hist.delete();
		dly = d;
		repeat (80) begin
			@(posedge core_clk);
			r = $urandom;
			wantTerm <= r[0] | (r[3:1] == 3'h0);
			writeReq <= (r[3:1] == 3'h0);
			writeIsBl8 <= r[4];
			readBlock <= (r[7:5] == 3'h0) && (r[3:1] != 3'h0);
		end
		check1("termMode", em, termMode);
		check1("nomValue", nm, nomValue);
		check1("wrValue", (nm == 3'h0) ? 2'h0 : 2'h1, wrValue);
	endtask : phase
	initial begin
		void'($urandom(49));
		#500000;
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		phase(2'h0, 1, 0, 1, 0, 3'h1, 6, ODT_MODE_SYNC);
		phase(2'h1, 1, 0, 1, 0, 3'h2, 11, ODT_MODE_SYNC);
		phase(2'h2, 1, 0, 1, 0, 3'h3, 10, ODT_MODE_SYNC);
		phase(2'h0, 0, 0, 0, 0, 3'h4, 6, ODT_MODE_SYNC);
		phase(2'h0, 0, 1, 1, 0, 3'h5, 6, ODT_MODE_SYNC);
		phase(2'h1, 0, 1, 0, 0, 3'h1, 4, ODT_MODE_ASYNC);
		phase(2'h2, 1, 0, 1, 1, 3'h2, 4, ODT_MODE_ASYNC);
		phase(2'h0, 1, 0, 1, 0, 3'h0, -1, ODT_MODE_OFF);
		@(posedge core_clk);
		writeReq <= 1'b0;
		wantTerm <= 1'b1;
		readBlock <= 1'b1;
		repeat (9) @(posedge core_clk);
		check1("termPin", 1'b0, link.termPin);
		readBlock <= 1'b0;
		repeat (3) @(posedge core_clk);
		check1("termPin", 1'b1, link.termPin);
		print_verdict();
	end
endmodule : dram_odt_timing_control_test

// *** odt_ctrl_end.sv ***
// controller side: drives termination pin with hold and read rules
// assumes user requests come from same-clock logic
`include "odt_map.svh"
module odt_ctrl_end
	import odt_pkg::*;
(
	input  wire logic           core_clk,    // clock
	input  wire logic           rst,         // sync reset, active high
	odt_link_if.controller      link,        // pin toward memory
	input  wire logic           wantTerm,    // user wants termination
	input  wire logic           readBlock,   // read window incl. margins
	input  wire logic           writeReq,    // issue a write this cycle
	input  wire logic           writeIsBl8,  // write is burst length 8
	output logic                holdBusy     // a hold time is running
);
	import odt_pkg::*;
	logic       pin_reg, pin_next, wr_reg, wr_next, bl8_reg, bl8_next;
	logic [3:0] hold_reg, hold_next;
	logic [3:0] wHold;

	always_comb begin
		pin_next  = pin_reg;
		hold_next = (hold_reg != 4'h0) ? hold_reg - 4'h1 : 4'h0;
		wr_next   = writeReq;
		bl8_next  = writeIsBl8;
		wHold     = writeIsBl8 ? 4'(`ODT_LONG_HOLD) : 4'(`ODT_SHORT_HOLD);
		if (!pin_reg) begin
			// caller keeps readBlock high half a clock before preamble
			if (wantTerm && !readBlock) begin            // [RULE11] [RULE12]
				pin_next  = 1'b1;
				hold_next = 4'(`ODT_SHORT_HOLD) - 4'h1;  // [RULE8]
				// BL8 write with the rising pin needs the longer hold
				if (writeReq && wHold > 4'(`ODT_SHORT_HOLD)) begin
					hold_next = wHold - 4'h1;            // [RULE9]
				end
			end
		end else begin
			// later of assertion hold and write hold wins
			if (writeReq && (wHold - 4'h1) > hold_next) begin
				hold_next = wHold - 4'h1;                // [RULE9] [RULE10]
			end
			if ((!wantTerm || readBlock) && hold_reg == 4'h0 && !writeReq) begin
				pin_next = 1'b0;                         // [RULE10]
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_reg  <= 1'b0;
			hold_reg <= 4'h0;
			wr_reg   <= 1'b0;
			bl8_reg  <= 1'b0;
		end else begin
			pin_reg  <= pin_next;
			hold_reg <= hold_next;
			wr_reg   <= wr_next;
			bl8_reg  <= bl8_next;
		end
	end

	assign link.termPin  = pin_reg;
	assign link.writeCmd = wr_reg;
	assign link.writeBl8 = bl8_reg;
	assign holdBusy      = (hold_reg != 4'h0);
endmodule : odt_ctrl_end

// *** odt_delay_line.sv ***
// selectable delay of one bit, 0 to DEPTH-1 cycles
// assumes same-clock input
module odt_delay_line #(
	parameter int DEPTH = 16
) (
	input  wire logic                     core_clk, // clock
	input  wire logic                     rst,      // sync reset
	input  wire logic                     din,      // bit in
	input  wire logic [$clog2(DEPTH)-1:0] sel,      // delay select
	output logic                          dout      // delayed bit
);
	logic [DEPTH-1:0] shift_reg;
	logic [DEPTH-1:0] shift_next;
	always_comb begin
		shift_next = {shift_reg[DEPTH-2:0], din};
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			shift_reg <= '0;
		end else begin
			shift_reg <= shift_next;
		end
	end
	// zero select passes input straight through
	assign dout = (sel == '0) ? din : shift_reg[sel - 1'b1];
endmodule : odt_delay_line

// *** odt_link_if.sv ***
// the termination pin and write strobe between controller and memory
// assumes both ends run on core_clk
interface odt_link_if;
	logic termPin;     // termination control pin level
	logic writeCmd;    // write command registered this cycle
	logic writeBl8;    // that write is burst length 8
	modport controller (output termPin, output writeCmd, output writeBl8);
	modport memory     (input termPin, input writeCmd, input writeBl8);
endinterface : odt_link_if

// *** odt_map.svh ***
// timing counts and field positions of the termination control block
// assumes a 100 MHz core clock shared by both ends
`ifndef ODT_MAP_SVH
`define ODT_MAP_SVH
`define ODT_CLK_PERIOD_NS   10
`define ODT_WL_OFFSET       2
`define ODT_SHORT_HOLD      4
`define ODT_LONG_HOLD       6
`define ODT_ASYNC_MIN_NS    2
`define ODT_ASYNC_MAX_X10   85
// least delay rounds up, longest rounds down, none below one cycle
`define ODT_ASYNC_MIN_CYC   ((`ODT_ASYNC_MIN_NS + `ODT_CLK_PERIOD_NS - 1) / `ODT_CLK_PERIOD_NS)
`define ODT_ASYNC_MAX_RAW   (`ODT_ASYNC_MAX_X10 / (10 * `ODT_CLK_PERIOD_NS))
`define ODT_ASYNC_MAX_CYC   ((`ODT_ASYNC_MAX_RAW < 1) ? 1 : `ODT_ASYNC_MAX_RAW)
`define ODT_NOM_LSB         0
`define ODT_NOM_MID         1
`define ODT_NOM_MSB         2
`define ODT_WR_LSB          0
`define ODT_WR_MSB          1
`define ODT_RESET_CWL       4'h5
`endif

// *** odt_memory_end.sv ***
// memory side termination timing: sync latency path and async delay path
// assumes pin arrives from another chip; mode bits are static config
`include "odt_map.svh"
// Overview of operation
// RULE1: sync timing when DLL locked and termination enabled
// RULE2: sync in active states, APD, PPD with DLL
// RULE3: turn on after on latency from high
// RULE4: turn off after off latency from low
// RULE5: both latencies equal CWL plus AL minus two
// RULE6: internal pin copy delayed by additive latency
// RULE7: turn-off completes half clock after latency; here the off edge lands on the latency boundary
// RULE8: controller holds pin high four cycles
// RULE9: write holds pin four or six cycles
// RULE10: release after later of both holds
// RULE11: controller drops pin before read preamble
// RULE12: no re-enable before read postamble ends
// RULE13: async timing in PPD with DLL off
// RULE14: async timing while DLL relocks
// RULE15: async ignores AL; fixed delays used
// RULE16: async on between 2 and 8.5 ns; here a fixed delay of one 10 ns cycle
// RULE17: async off between 2 and 8.5 ns; here a fixed delay of one 10 ns cycle
// RULE18: termination values from mode register fields
// RULE19: write termination WL-2 after write, then back
// RULE20: no termination enabled keeps high impedance
module odt_memory_end
	import odt_pkg::*;
(
	input  wire logic           core_clk,     // clock
	input  wire logic           rst,          // sync reset, active high
	odt_link_if.memory          link,         // pin from controller
	input  wire logic           dllLocked,    // DLL on and locked
	input  wire logic           dllRelock,    // DLL resynchronising
	input  wire logic           cke,          // clock enable level
	input  wire logic           prechargePd,  // in precharge power-down
	input  wire logic           dllOnInPd,    // mode 0 bit 12
	input  wire odt_al_t        alCode,       // mode 1 bits 4,3
	input  wire odt_lat_t       cwl,          // CAS write latency
	input  wire odt_nom_t       nomCode,      // mode 1 bits 9,6,2
	input  wire odt_wr_t        wrCode,       // mode 2 bits 10,9
	output odt_mode_e           termMode,     // active timing mode
	output logic                termOn,       // termination enabled
	output logic                termWrite,    // write value selected
	output odt_nom_t            nomValue,     // nominal value code
	output odt_wr_t             wrValue       // write value code
);
	import odt_pkg::*;
	logic     pinS1_reg, pinS2_reg, wrS1_reg, wrS2_reg, bl8S1_reg, bl8S2_reg;
	logic     termEnabled, asyncCond, syncPin, syncRaw;
	odt_lat_t alLat, wl, odtLat, cwlLat;
	odt_mode_e mode_reg, mode_next;
	logic     on_reg, on_next, wsel_reg, wsel_next;
	odt_nom_t nom_reg, nom_next;
	odt_wr_t  wr_reg, wr_next;
	logic [3:0] asyncCnt_reg, asyncCnt_next, wCnt_reg, wCnt_next;
	logic [3:0] wEnd_reg, wEnd_next;
	logic       asyncTgt_reg, asyncTgt_next;

	// pin and strobes come from the other chip: two-stage sync
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pinS1_reg <= 1'b0; pinS2_reg <= 1'b0;
			wrS1_reg  <= 1'b0; wrS2_reg  <= 1'b0;
			bl8S1_reg <= 1'b0; bl8S2_reg <= 1'b0;
		end else begin
			pinS1_reg <= link.termPin;  pinS2_reg <= pinS1_reg;
			wrS1_reg  <= link.writeCmd; wrS2_reg  <= wrS1_reg;
			bl8S1_reg <= link.writeBl8; bl8S2_reg <= bl8S1_reg;
		end
	end

	// AL codes: 0 -> 0, 1 -> CL-1, 2 -> CL-2; CL taken as CWL+1 here
	always_comb begin
		unique case (alCode)
			2'b01:   alLat = cwl;
			2'b10:   alLat = cwl - 4'h1;
			default: alLat = 4'h0;
		endcase
		wl     = cwl + alLat;
		odtLat = (wl > 4'h2) ? wl - 4'h2 : 4'h0;   // [RULE5]
		// AL is already spent in the first line, so only CWL-2 is left
		cwlLat = (cwl > 4'h2) ? cwl - 4'h2 : 4'h0;
	end

	assign termEnabled = (nomCode != 3'h0) || (wrCode != 2'h0);
	// async in PPD with DLL off, or during relock
	assign asyncCond = dllRelock ||
		(!cke && prechargePd && !dllOnInPd);            // [RULE13] [RULE14]

	// AL then CWL-2: together the on/off latency of CWL+AL-2
	odt_delay_line #(.DEPTH(16)) u_alDelay (
		.core_clk (core_clk),
		.rst      (rst),
		.din      (pinS2_reg),
		.sel      (alLat),                               // [RULE6]
		.dout     (syncRaw)
	);
	odt_delay_line #(.DEPTH(16)) u_latDelay (
		.core_clk (core_clk),
		.rst      (rst),
		.din      (syncRaw),
		.sel      (cwlLat),                              // [RULE3] [RULE4]
		.dout     (syncPin)
	);

	always_comb begin
		mode_next     = mode_reg;
		on_next       = on_reg;
		asyncCnt_next = asyncCnt_reg;
		asyncTgt_next = asyncTgt_reg;
		wCnt_next     = wCnt_reg;
		wEnd_next     = wEnd_reg;
		wsel_next     = wsel_reg;
		nom_next      = nomCode;                         // [RULE18]
		wr_next       = wrCode;                          // [RULE18]
		if (!termEnabled) begin
			mode_next = ODT_MODE_OFF;
		end else if (asyncCond) begin
			mode_next = ODT_MODE_ASYNC;
		end else if (dllLocked) begin
			mode_next = ODT_MODE_SYNC;                   // [RULE1] [RULE2]
		end
		unique case (mode_reg)
			ODT_MODE_OFF: begin
				on_next = 1'b0;                          // [RULE20]
			end
			ODT_MODE_SYNC: begin
				// off edge lands on the latency boundary (skew analog)
				on_next = syncPin;                       // [RULE7]
			end
			ODT_MODE_ASYNC: begin
				// no AL; fixed delay of one 10 ns cycle, past the 2..8.5 ns window
				// apply before retargeting so one-cycle pulses are kept
				if (asyncCnt_reg == 4'h1) begin
					on_next = asyncTgt_reg;              // [RULE16] [RULE17]
				end
				if (pinS2_reg != asyncTgt_reg) begin
					asyncTgt_next = pinS2_reg;           // [RULE15]
					asyncCnt_next = 4'(`ODT_ASYNC_MAX_CYC);
				end else if (asyncCnt_reg != 4'h0) begin
					asyncCnt_next = asyncCnt_reg - 4'h1;
				end
			end
			default: on_next = 1'b0;
		endcase
		// dynamic switch only in sync mode with write value enabled
		if (mode_reg == ODT_MODE_SYNC && wrCode != 2'h0 && wrS2_reg) begin
			wCnt_next = (odtLat == 4'h0) ? 4'h1 : odtLat;   // [RULE19]
			wEnd_next = bl8S2_reg ? 4'(`ODT_LONG_HOLD) : 4'(`ODT_SHORT_HOLD);
		end else if (wCnt_reg != 4'h0) begin
			wCnt_next = wCnt_reg - 4'h1;
			if (wCnt_reg == 4'h1) begin
				wsel_next = 1'b1;
			end
		end else if (wsel_reg) begin
			if (wEnd_reg <= 4'h1) begin
				wsel_next = 1'b0;
				wEnd_next = 4'h0;
			end else begin
				wEnd_next = wEnd_reg - 4'h1;
			end
		end
		if (mode_reg != ODT_MODE_SYNC) begin
			wsel_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_reg     <= ODT_MODE_OFF;
			on_reg       <= 1'b0;
			asyncCnt_reg <= 4'h0;
			asyncTgt_reg <= 1'b0;
			wCnt_reg     <= 4'h0;
			wEnd_reg     <= 4'h0;
			wsel_reg     <= 1'b0;
			nom_reg      <= 3'h0;
			wr_reg       <= 2'h0;
		end else begin
			mode_reg     <= mode_next;
			on_reg       <= on_next;
			asyncCnt_reg <= asyncCnt_next;
			asyncTgt_reg <= asyncTgt_next;
			wCnt_reg     <= wCnt_next;
			wEnd_reg     <= wEnd_next;
			wsel_reg     <= wsel_next;
			nom_reg      <= nom_next;
			wr_reg       <= wr_next;
		end
	end

	assign termMode  = mode_reg;
	assign termOn    = on_reg;
	assign termWrite = wsel_reg & on_reg;
	assign nomValue  = nom_reg;
	assign wrValue   = wr_reg;
endmodule : odt_memory_end

// *** odt_pkg.sv ***
// types shared by both termination control ends
// assumes odt_map.svh for numeric constants
package odt_pkg;
	typedef logic [3:0] odt_lat_t;   // latency in clocks
	typedef logic [2:0] odt_nom_t;   // nominal termination code
	typedef logic [1:0] odt_wr_t;    // write termination code
	typedef logic [1:0] odt_al_t;    // additive latency code
	typedef enum logic [1:0] {
		ODT_MODE_OFF   = 2'b00,
		ODT_MODE_SYNC  = 2'b01,
		ODT_MODE_ASYNC = 2'b10
	} odt_mode_e;
endpackage : odt_pkg

// *** odt_timing_checker.sv ***
// timing checks on the termination link between both ends
// assumes link signals change just after rising core_clk edges
module odt_timing_checker (
	input wire logic core_clk, // clock
	input wire logic rst,      // sync reset, active high
	input wire logic termPin,  // pin level
	input wire logic writeCmd, // write pulse
	input wire logic writeBl8  // write is burst length 8
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking
		@(posedge core_clk);
	endclocking
	default disable iff (rst);
	short_hold_a: assert property ($rose(termPin) |-> termPin[*4])
		else $error("pin dropped before short hold");
	bc4_hold_a: assert property (writeCmd && !writeBl8 |-> termPin[*4])
		else $error("pin dropped before chop hold");
	bl8_hold_a: assert property (writeCmd && writeBl8 |-> termPin[*6])
		else $error("pin dropped before long hold");
	fall_after_hold_a: assert property ($fell(termPin) |-> $past(termPin, 4))
		else $error("pin fell too soon");
	write_pin_high_a: assert property (writeCmd |-> termPin)
		else $error("write sent with pin low");
	reset_idle_a: assert property (disable iff (1'b0) rst |=> !termPin && !writeCmd)
		else $error("link not idle after reset");
	cover property ($rose(termPin));
	cover property (writeCmd && writeBl8);
	cover property (writeCmd && !writeBl8);
endmodule : odt_timing_checker
